// ---- logic/display_ctrl_packet_parser.sv ----
// Command frame receiver, decoder and ACK/NAK responder with input FIFO
// Overview of operation
// [R01] Frame: start, address, three command bytes, count, header check, data, data check.
// [R02] Frames are seven to eighty-two bytes; others are invalid.
// [R03] Start byte 07 is command, 06 is ACK, 15 is NAK.
// [R04] Host starts every command frame with 07.
// [R05] Every command gets a reply: ACK on success, NAK on failure.
// [R06] Address must be broadcast FF, the only supported address.
// [R07] Reply address byte identifies the responding unit.
// [R08] Count byte is data length, zero to seventy-four.
// [R09] Bytes 0 to 6 sum to FF modulo 256; receiver checks it.
// [R10] Bad header check gets a NAK reply.
// [R11] Data bytes are present only when the count is nonzero.
// [R12] Nonzero count adds a data check; data plus check sum to FF.
// [R13] Bad data check gets a NAK reply.
// [R14] Decode brightness group 42 52 with 49, 4C, 4D, 54, 55.
// [R15] Decode colour package fetch, package count and elapsed-time queries.
// [R16] Decode scaler and keypad firmware version queries.
// [R17] Decode mains detect command and its status query.
// [R18] Decode buzzer, glass floor, potentiometer, brightness, serial disable, chart mode.
// [R19] Scaler version query is 07 FF 53 57 49 00 06.
// [R20] Idle receiver drops bytes other than 07 to resynchronise.
// [R21] Replies repeat the command bytes and use the same checksums.
`timescale 1ns/1ps
`default_nettype none

module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rstn_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic      [WIDTH-1:0] out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out  = mem[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      wr_q         <= '0;
      rd_q         <= '0;
      cnt_q        <= '0;
      in_ready_out <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q        <= cnt_d;
      in_ready_out <= (cnt_d != (AW+1)'(DEPTH));
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wr_q] <= in_data_in;
    end
  end
endmodule : byte_fifo

module display_ctrl_packet_parser #(
  parameter logic [7:0] UNIT_ADDR = 8'hFF
) (
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  input  wire logic [7:0]  rx_data_in,
  input  wire logic        rx_valid_in,
  output logic             rx_ready_out,
  output logic [7:0]       tx_data_out,
  output logic             tx_valid_out,
  input  wire logic        tx_ready_in,
  output logic [7:0]       payload_data_out,
  output logic             payload_valid_out,
  output logic             cmd_valid_out,
  output logic [23:0]      cmd_code_out,
  output logic [7:0]       payload_count_out,
  input  wire logic        done_in,
  input  wire logic        ok_in,
  input  wire logic        rsp_has_data_in,
  input  wire logic [7:0]  rsp_data_in
);
  dcp_pkg::state_type state_q;
  logic [7:0]  f_data;
  logic        f_valid;
  logic        f_ready;
  logic        take;
  logic [2:0]  hidx_q;
  logic [7:0]  hsum_q;
  logic [7:0]  dsum_q;
  logic [7:0]  left_q;
  logic [7:0]  addr_q;
  logic        hdr_end;
  logic        hdr_bad;
  logic        known;
  logic        go_wait;
  logic        ack_q;
  logic        rsp_has_q;
  logic [7:0]  rsp_data_q;
  logic [3:0]  tx_idx_q;
  logic [3:0]  tx_last;
  logic [7:0]  start_byte;
  logic [7:0]  hchk_byte;

  function automatic logic is_known(input logic [23:0] c);
    case (c)
      dcp_pkg::BACKLIGHT_FLOOR_CMD, dcp_pkg::KEYPAD_LED_LEVEL_CMD, dcp_pkg::BACKLIGHT_CEILING_CMD,
      dcp_pkg::USER_BRIGHTNESS_CMD, dcp_pkg::BRILLIANCE_BUTTON_CMD,
      dcp_pkg::COLOUR_PACKAGE_FETCH_CMD, dcp_pkg::COLOUR_PACKAGE_COUNT_QUERY, dcp_pkg::ELAPSED_TIME_QUERY,
      dcp_pkg::SCALER_VERSION_QUERY, dcp_pkg::KEYPAD_VERSION_QUERY,
      dcp_pkg::MAINS_DETECT_CMD, dcp_pkg::MAINS_DETECT_QUERY,
      dcp_pkg::BUZZER_CMD, dcp_pkg::GLASS_FLOOR_BRIGHTNESS_CMD, dcp_pkg::POTENTIOMETER_CMD,
      dcp_pkg::BRIGHTNESS_CMD, dcp_pkg::SERIAL_CMD_DISABLE, dcp_pkg::CHART_MODE_SELECT_CMD:
        is_known = 1'b1; // [R14] [R15] [R16] [R17] [R18] [R19]
      default: is_known = 1'b0;
    endcase
  endfunction : is_known

  byte_fifo #(
    .WIDTH (8),
    .DEPTH (dcp_pkg::FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys_in    (clk_sys_in),
    .rstn_in       (rstn_in),
    .in_data_in    (rx_data_in),
    .in_valid_in   (rx_valid_in),
    .in_ready_out  (rx_ready_out),
    .out_data_out  (f_data),
    .out_valid_out (f_valid),
    .out_ready_in  (f_ready)
  );

  // Receive side stalls while a command is served or a reply is sent
  assign f_ready = (state_q == dcp_pkg::ST_IDLE) || (state_q == dcp_pkg::ST_HDR) ||
                   (state_q == dcp_pkg::ST_DATA) || (state_q == dcp_pkg::ST_DCHK);
  assign take    = f_valid && f_ready;
  assign known   = is_known(cmd_code_out);
  assign hdr_end = take && (state_q == dcp_pkg::ST_HDR) && (hidx_q == dcp_pkg::IDX_HCHK);
  assign hdr_bad = (8'(hsum_q + f_data) != dcp_pkg::CHECK_SUM) ||            // [R09] [R10]
                   (addr_q != dcp_pkg::BCAST_ADDR) ||                        // [R06]
                   (payload_count_out > dcp_pkg::MAX_COUNT);                 // [R02] [R08]
  assign go_wait = known && ((hdr_end && !hdr_bad && payload_count_out == 8'h00) ||  // [R11]
                   (take && state_q == dcp_pkg::ST_DCHK &&
                    8'(dsum_q + f_data) == dcp_pkg::CHECK_SUM));             // [R12] [R13]

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      state_q <= dcp_pkg::ST_IDLE;
    end else begin
      case (state_q)
        dcp_pkg::ST_IDLE: begin
          if (take && f_data == dcp_pkg::START_CMD) begin // [R03] [R04] [R20]
            state_q <= dcp_pkg::ST_HDR;
          end
        end
        dcp_pkg::ST_HDR: begin
          if (hdr_end) begin
            if (go_wait) begin
              state_q <= dcp_pkg::ST_WAIT;
            end else if (hdr_bad || payload_count_out == 8'h00) begin
              state_q <= dcp_pkg::ST_SEND; // [R10]
            end else begin
              state_q <= dcp_pkg::ST_DATA;
            end
          end
        end
        dcp_pkg::ST_DATA: begin
          if (take && left_q == 8'h01) begin
            state_q <= dcp_pkg::ST_DCHK;
          end
        end
        dcp_pkg::ST_DCHK: begin
          if (take) begin
            state_q <= go_wait ? dcp_pkg::ST_WAIT : dcp_pkg::ST_SEND; // [R13]
          end
        end
        dcp_pkg::ST_WAIT: begin
          if (done_in) begin
            state_q <= dcp_pkg::ST_SEND; // [R05]
          end
        end
        dcp_pkg::ST_SEND: begin
          if (tx_valid_out && tx_ready_in && tx_idx_q == tx_last) begin
            state_q <= dcp_pkg::ST_IDLE;
          end
        end
        default: state_q <= dcp_pkg::ST_IDLE;
      endcase
    end
  end

  // Header capture and running sums
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      hidx_q            <= 3'h0;
      hsum_q            <= 8'h00;
      dsum_q            <= 8'h00;
      left_q            <= 8'h00;
      addr_q            <= 8'h00;
      cmd_code_out      <= 24'h000000;
      payload_count_out <= 8'h00;
    end else if (take) begin
      if (state_q == dcp_pkg::ST_IDLE) begin
        hidx_q <= dcp_pkg::IDX_ADDR;
        hsum_q <= f_data;
      end else if (state_q == dcp_pkg::ST_HDR) begin
        hidx_q <= hidx_q + 3'h1;
        hsum_q <= 8'(hsum_q + f_data);
        case (hidx_q) // [R01]
          dcp_pkg::IDX_ADDR:  addr_q <= f_data;
          dcp_pkg::IDX_CMD0:  cmd_code_out[23:16] <= f_data;
          dcp_pkg::IDX_CMD1:  cmd_code_out[15:8] <= f_data;
          dcp_pkg::IDX_CMD2:  cmd_code_out[7:0] <= f_data;
          dcp_pkg::IDX_COUNT: payload_count_out <= f_data;
          default: begin
            dsum_q <= 8'h00;
            left_q <= payload_count_out;
          end
        endcase
      end else if (state_q == dcp_pkg::ST_DATA) begin
        dsum_q <= 8'(dsum_q + f_data); // [R12]
        left_q <= left_q - 8'h01;
      end
    end
  end

  // Payload stream and command strobe towards the application
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      payload_valid_out <= 1'b0;
      payload_data_out  <= 8'h00;
      cmd_valid_out     <= 1'b0;
    end else begin
      payload_valid_out <= take && (state_q == dcp_pkg::ST_DATA);
      payload_data_out  <= f_data;
      cmd_valid_out     <= go_wait;
    end
  end

  // Reply status: any error path leaves a NAK
  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      ack_q      <= 1'b0;
      rsp_has_q  <= 1'b0;
      rsp_data_q <= 8'h00;
    end else if (take && state_q == dcp_pkg::ST_IDLE) begin
      ack_q     <= 1'b0;
      rsp_has_q <= 1'b0;
    end else if (state_q == dcp_pkg::ST_WAIT && done_in) begin
      ack_q      <= ok_in; // [R05]
      rsp_has_q  <= rsp_has_data_in;
      rsp_data_q <= rsp_data_in;
    end
  end

  assign tx_last    = rsp_has_q ? dcp_pkg::TX_LAST_DAT : dcp_pkg::TX_LAST_HDR;
  assign start_byte = ack_q ? dcp_pkg::START_ACK : dcp_pkg::START_NAK; // [R03]
  assign hchk_byte  = 8'(dcp_pkg::CHECK_SUM - (start_byte + UNIT_ADDR + cmd_code_out[23:16] +
                      cmd_code_out[15:8] + cmd_code_out[7:0] + {7'h00, rsp_has_q})); // [R21]

  function automatic logic [7:0] reply_byte(input logic [3:0] i);
    case (i)
      4'h0:    reply_byte = start_byte;
      4'h1:    reply_byte = UNIT_ADDR; // [R07]
      4'h2:    reply_byte = cmd_code_out[23:16];
      4'h3:    reply_byte = cmd_code_out[15:8];
      4'h4:    reply_byte = cmd_code_out[7:0];
      4'h5:    reply_byte = {7'h00, rsp_has_q};
      4'h6:    reply_byte = hchk_byte;
      4'h7:    reply_byte = rsp_data_q;
      default: reply_byte = 8'(dcp_pkg::CHECK_SUM - rsp_data_q); // [R21]
    endcase
  endfunction : reply_byte

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      tx_idx_q     <= 4'h0;
      tx_valid_out <= 1'b0;
      tx_data_out  <= 8'h00;
    end else if (state_q != dcp_pkg::ST_SEND) begin
      tx_idx_q     <= 4'h0;
      tx_valid_out <= 1'b0;
    end else if (!tx_valid_out) begin
      tx_valid_out <= 1'b1;
      tx_data_out  <= reply_byte(tx_idx_q);
    end else if (tx_ready_in) begin
      if (tx_idx_q == tx_last) begin
        tx_valid_out <= 1'b0;
      end else begin
        tx_idx_q    <= tx_idx_q + 4'h1;
        tx_data_out <= reply_byte(tx_idx_q + 4'h1);
      end
    end
  end

  property p_resync;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (state_q == dcp_pkg::ST_IDLE && f_valid && f_data != dcp_pkg::START_CMD) |=> state_q == dcp_pkg::ST_IDLE;
  endproperty
  a_resync: assert property (p_resync) else $error("stray byte left idle"); // [R20]

  property p_hdr_nak;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (hdr_end && hdr_bad) |=> (state_q == dcp_pkg::ST_SEND && !ack_q) ##1 (tx_data_out == dcp_pkg::START_NAK);
  endproperty
  a_hdr_nak: assert property (p_hdr_nak) else $error("bad header not answered by NAK"); // [R10]

  property p_data_nak;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (take && state_q == dcp_pkg::ST_DCHK && 8'(dsum_q + f_data) != dcp_pkg::CHECK_SUM)
      |=> state_q == dcp_pkg::ST_SEND && !ack_q;
  endproperty
  a_data_nak: assert property (p_data_nak) else $error("bad data check not answered by NAK"); // [R13]

  property p_done_ack;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (state_q == dcp_pkg::ST_WAIT && done_in) |=> state_q == dcp_pkg::ST_SEND && ack_q == $past(ok_in);
  endproperty
  a_done_ack: assert property (p_done_ack) else $error("reply kind differs from result"); // [R05]

  property p_start_byte;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (tx_valid_out && tx_idx_q == 4'h0) |-> tx_data_out == (ack_q ? dcp_pkg::START_ACK : dcp_pkg::START_NAK);
  endproperty
  a_start_byte: assert property (p_start_byte) else $error("wrong reply start byte"); // [R03]

  property p_unit_addr;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (tx_valid_out && tx_idx_q == 4'h1) |-> tx_data_out == UNIT_ADDR;
  endproperty
  a_unit_addr: assert property (p_unit_addr) else $error("reply address wrong"); // [R07]

  property p_known;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    cmd_valid_out |-> is_known(cmd_code_out) && state_q == dcp_pkg::ST_WAIT &&
                      addr_q == dcp_pkg::BCAST_ADDR && payload_count_out <= dcp_pkg::MAX_COUNT;
  endproperty
  a_known: assert property (p_known) else $error("unknown command dispatched"); // [R06] [R15]

  property p_no_data;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (hdr_end && !hdr_bad && payload_count_out == 8'h00) |=> state_q != dcp_pkg::ST_DATA;
  endproperty
  a_no_data: assert property (p_no_data) else $error("zero count frame expects data"); // [R11]

  property p_count_max;
    @(posedge clk_sys_in) disable iff (!rstn_in)
    (state_q == dcp_pkg::ST_DATA) |-> left_q != 8'h00 && left_q <= dcp_pkg::MAX_COUNT;
  endproperty
  a_count_max: assert property (p_count_max) else $error("data count out of range"); // [R08]
endmodule : display_ctrl_packet_parser

`default_nettype wire

// ---- pkg/dcp_pkg.sv ----
// Constants and types of the display control packet parser
package dcp_pkg;
  localparam logic [7:0]  START_CMD   = 8'h07;
  localparam logic [7:0]  START_ACK   = 8'h06;
  localparam logic [7:0]  START_NAK   = 8'h15;
  localparam logic [7:0]  BCAST_ADDR  = 8'hFF;
  localparam logic [7:0]  CHECK_SUM   = 8'hFF;
  localparam logic [7:0]  MAX_COUNT   = 8'h4A;
  localparam logic [2:0]  IDX_ADDR    = 3'h1;
  localparam logic [2:0]  IDX_CMD0    = 3'h2;
  localparam logic [2:0]  IDX_CMD1    = 3'h3;
  localparam logic [2:0]  IDX_CMD2    = 3'h4;
  localparam logic [2:0]  IDX_COUNT   = 3'h5;
  localparam logic [2:0]  IDX_HCHK    = 3'h6;
  localparam logic [3:0]  TX_LAST_HDR = 4'h6;
  localparam logic [3:0]  TX_LAST_DAT = 4'h8;
  localparam int          FIFO_DEPTH  = 16;
  localparam logic [23:0] BACKLIGHT_FLOOR_CMD        = 24'h425249;
  localparam logic [23:0] KEYPAD_LED_LEVEL_CMD       = 24'h42524C;
  localparam logic [23:0] BACKLIGHT_CEILING_CMD      = 24'h42524D;
  localparam logic [23:0] USER_BRIGHTNESS_CMD        = 24'h425254;
  localparam logic [23:0] BRILLIANCE_BUTTON_CMD      = 24'h425255;
  localparam logic [23:0] BUZZER_CMD                 = 24'h425A5A;
  localparam logic [23:0] COLOUR_PACKAGE_FETCH_CMD   = 24'h444C4E;
  localparam logic [23:0] COLOUR_PACKAGE_COUNT_QUERY = 24'h444C3F;
  localparam logic [23:0] ELAPSED_TIME_QUERY         = 24'h455443;
  localparam logic [23:0] GLASS_FLOOR_BRIGHTNESS_CMD = 24'h474D42;
  localparam logic [23:0] POTENTIOMETER_CMD          = 24'h504F54;
  localparam logic [23:0] SCALER_VERSION_QUERY       = 24'h535749;
  localparam logic [23:0] KEYPAD_VERSION_QUERY       = 24'h53574B;
  localparam logic [23:0] MAINS_DETECT_CMD           = 24'h414446;
  localparam logic [23:0] MAINS_DETECT_QUERY         = 24'h41443F;
  localparam logic [23:0] BRIGHTNESS_CMD             = 24'h424C49;
  localparam logic [23:0] SERIAL_CMD_DISABLE         = 24'h445546;
  localparam logic [23:0] CHART_MODE_SELECT_CMD      = 24'h454D53;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_HDR  = 3'h1,
    ST_DATA = 3'h3,
    ST_DCHK = 3'h2,
    ST_WAIT = 3'h6,
    ST_SEND = 3'h7
  } state_type;
endpackage : dcp_pkg

// ---- verification/host_model.sv ----
// Host side model: sends queued frame bytes, collects reply bytes with random stalls
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input  wire logic       clk_sys_in,
  input  wire logic       rstn_in,
  output logic [7:0]      rx_data_out,
  output logic            rx_valid_out,
  input  wire logic       rx_ready_in,
  input  wire logic [7:0] tx_data_in,
  input  wire logic       tx_valid_in,
  output logic            tx_ready_out
);
  logic [7:0] send_q[$];
  logic [7:0] got_q[$];
  int         seed = 28654;
  logic       took = 1'b0;

  initial begin
    rx_data_out  = 8'h00;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
  end

  always @(posedge clk_sys_in) begin
    took = rx_valid_out && rx_ready_in;
    if (tx_valid_in && tx_ready_out) got_q.push_back(tx_data_in);
  end

  // Byte held until taken; idle line shows changing data
  always @(negedge clk_sys_in) begin
    tx_ready_out = rstn_in && (($random(seed) & 3) != 0);
    if (!rx_valid_out || took) begin
      took = 1'b0;
      if (rstn_in && send_q.size() > 0) begin
        rx_data_out  = send_q.pop_front();
        rx_valid_out = 1'b1;
      end else begin
        rx_valid_out = 1'b0;
        rx_data_out  = ~rx_data_out;
      end
    end
  end
endmodule : host_model

`default_nettype wire

// ---- verification/testbench.sv ----
// Self-checking testbench of the display control packet parser
`timescale 1ns/1ps
`default_nettype none

module testbench;
  typedef logic [7:0] bytes_type[$];
  logic        clk_sys_in = 1'b0;
  logic        rstn_in    = 1'b0;
  logic [7:0]  rx_data;
  logic        rx_valid;
  logic        rx_ready;
  logic [7:0]  tx_data;
  logic        tx_valid;
  logic        tx_ready;
  logic [7:0]  payload_data;
  logic        payload_valid;
  logic        cmd_valid;
  logic [23:0] cmd_code;
  logic [7:0]  payload_count;
  logic        done_in         = 1'b0;
  logic        ok_in           = 1'b0;
  logic        rsp_has_data_in = 1'b0;
  logic [7:0]  rsp_data_in     = 8'h00;
  logic        pend            = 1'b0;
  logic        hold            = 1'b0;
  logic [23:0] last_code;
  logic [7:0]  last_count;
  bytes_type   pay_q;
  bytes_type   f;
  int          n_cmd = 0;
  int          fails = 0;
  int          n_compared = 0;
  int          seed = 28654;
  int          cnt;
  logic [23:0] codes[18] = '{dcp_pkg::BACKLIGHT_FLOOR_CMD, dcp_pkg::KEYPAD_LED_LEVEL_CMD,
    dcp_pkg::BACKLIGHT_CEILING_CMD, dcp_pkg::USER_BRIGHTNESS_CMD, dcp_pkg::BRILLIANCE_BUTTON_CMD,
    dcp_pkg::BUZZER_CMD, dcp_pkg::COLOUR_PACKAGE_FETCH_CMD, dcp_pkg::COLOUR_PACKAGE_COUNT_QUERY,
    dcp_pkg::ELAPSED_TIME_QUERY, dcp_pkg::GLASS_FLOOR_BRIGHTNESS_CMD, dcp_pkg::POTENTIOMETER_CMD,
    dcp_pkg::SCALER_VERSION_QUERY, dcp_pkg::KEYPAD_VERSION_QUERY, dcp_pkg::MAINS_DETECT_CMD,
    dcp_pkg::MAINS_DETECT_QUERY, dcp_pkg::BRIGHTNESS_CMD, dcp_pkg::SERIAL_CMD_DISABLE,
    dcp_pkg::CHART_MODE_SELECT_CMD};

  always #12.5 clk_sys_in = ~clk_sys_in;

  display_ctrl_packet_parser #(.UNIT_ADDR(8'hFF)) uut (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .rx_data_in(rx_data), .rx_valid_in(rx_valid),
    .rx_ready_out(rx_ready), .tx_data_out(tx_data), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
    .payload_data_out(payload_data), .payload_valid_out(payload_valid), .cmd_valid_out(cmd_valid),
    .cmd_code_out(cmd_code), .payload_count_out(payload_count), .done_in(done_in), .ok_in(ok_in),
    .rsp_has_data_in(rsp_has_data_in), .rsp_data_in(rsp_data_in));

  host_model host (
    .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .rx_data_out(rx_data), .rx_valid_out(rx_valid),
    .rx_ready_in(rx_ready), .tx_data_in(tx_data), .tx_valid_in(tx_valid), .tx_ready_out(tx_ready));

  always @(posedge clk_sys_in) begin
    if (payload_valid) pay_q.push_back(payload_data);
    if (cmd_valid) begin
      n_cmd++;
      pend = 1'b1;
      last_code = cmd_code;
      last_count = payload_count;
    end
  end

  // Application answers one cycle after the command pulse unless held
  always @(negedge clk_sys_in) begin
    done_in = pend && !hold;
    if (done_in) pend = 1'b0;
  end

  function automatic bytes_type frame(logic [23:0] code, logic [7:0] addr, int n, logic [7:0] hx, logic [7:0] dx);
    bytes_type  q = '{8'h07, addr, code[23:16], code[15:8], code[7:0], 8'(n)};
    logic [7:0] s = 8'h00;
    foreach (q[i]) s += q[i];
    q.push_back(8'hFF - s + hx);
    s = 8'h00;
    for (int i = 0; i < n; i++) begin
      q.push_back(8'($random(seed)));
      s += q[7 + i];
    end
    if (n > 0) q.push_back(8'hFF - s + dx);
    return q;
  endfunction : frame

  function automatic bytes_type reply(logic [7:0] st, logic [23:0] code, logic hd, logic [7:0] d);
    bytes_type  q = '{st, 8'hFF, code[23:16], code[15:8], code[7:0], {7'h00, hd}};
    logic [7:0] s = 8'h00;
    foreach (q[i]) s += q[i];
    q.push_back(8'hFF - s);
    if (hd) begin
      q.push_back(d);
      q.push_back(8'hFF - d);
    end
    return q;
  endfunction : reply

  task automatic check(logic [31:0] seen, logic [31:0] expv);
    n_compared++;
    if (seen !== expv) begin
      fails++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, expv);
    end
  endtask : check

  task automatic wait_reply(int n);
    int t = 0;
    while (host.got_q.size() < n && t < 3000) begin
      @(posedge clk_sys_in);
      t++;
    end
    if (t >= 3000) fails++;
    repeat (4) @(posedge clk_sys_in);
  endtask : wait_reply

  task automatic run(bytes_type q, logic good, int plen);
    bytes_type exp;
    int        n0;
    @(negedge clk_sys_in);
    ok_in = 1'($random(seed));
    rsp_has_data_in = 1'($random(seed));
    rsp_data_in = 8'($random(seed));
    n0 = n_cmd;
    pay_q.delete();
    host.got_q.delete();
    foreach (q[i]) host.send_q.push_back(q[i]);
    exp = reply((good && ok_in) ? dcp_pkg::START_ACK : dcp_pkg::START_NAK, {q[2], q[3], q[4]},
                good && rsp_has_data_in, rsp_data_in);
    wait_reply(exp.size());
    check(32'(n_cmd - n0), 32'(good));
    check(32'(host.got_q.size()), 32'(exp.size()));
    foreach (exp[i]) check(host.got_q[i], exp[i]);
    check(32'(pay_q.size()), 32'(plen));
    foreach (pay_q[i]) check(pay_q[i], q[7 + i]);
    if (good) check(last_code, {q[2], q[3], q[4]});
    if (good) check(last_count, q[5]);
  endtask : run

  task automatic wrap_up();
    $display("compared %0d, wrong %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  initial begin
    #1500000;
    fails++;
    wrap_up();
  end

  initial begin
    repeat (4) @(negedge clk_sys_in);
    check(rx_ready, 1'b0);
    rstn_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    check(rx_ready, 1'b1);
    run('{8'h07, 8'hFF, 8'h53, 8'h57, 8'h49, 8'h00, 8'h06}, 1'b1, 0);
    foreach (codes[i]) run(frame(codes[i], 8'hFF, 0, 8'h00, 8'h00), 1'b1, 0);
    for (int k = 0; k < 6; k++) begin
      cnt = 1 + ($random(seed) & 63);
      run(frame(codes[k], 8'hFF, cnt, 8'h00, 8'h00), 1'b1, cnt);
    end
    run(frame(dcp_pkg::USER_BRIGHTNESS_CMD, 8'hFF, 74, 8'h00, 8'h00), 1'b1, 74);
    f = frame(dcp_pkg::BUZZER_CMD, 8'hFF, 75, 8'h00, 8'h00);
    run(f[0:6], 1'b0, 0);
    run(frame(dcp_pkg::BUZZER_CMD, 8'hFF, 0, 8'h01, 8'h00), 1'b0, 0);
    run(frame(dcp_pkg::BUZZER_CMD, 8'hFE, 0, 8'h00, 8'h00), 1'b0, 0);
    run(frame(24'h414141, 8'hFF, 0, 8'h00, 8'h00), 1'b0, 0);
    run(frame(dcp_pkg::BACKLIGHT_FLOOR_CMD, 8'hFF, 1, 8'h00, 8'h01), 1'b0, 1);
    // Fill the input buffer while the answer is held back
    @(negedge clk_sys_in);
    hold = 1'b1;
    ok_in = 1'b1;
    rsp_has_data_in = 1'b0;
    host.got_q.delete();
    f = '{8'h55, 8'h20};
    f = {f, frame(dcp_pkg::POTENTIOMETER_CMD, 8'hFF, 0, 8'h00, 8'h00),
         frame(dcp_pkg::SCALER_VERSION_QUERY, 8'hFF, 0, 8'h00, 8'h00)};
    repeat (10) f.push_back(8'hA5);
    foreach (f[i]) host.send_q.push_back(f[i]);
    cnt = n_cmd;
    repeat (60) @(negedge clk_sys_in);
    check(32'(n_cmd - cnt), 32'd1);
    check(rx_ready, 1'b0);
    hold = 1'b0;
    wait_reply(14);
    repeat (20) @(posedge clk_sys_in);
    f = {reply(dcp_pkg::START_ACK, dcp_pkg::POTENTIOMETER_CMD, 1'b0, 8'h00),
         reply(dcp_pkg::START_ACK, dcp_pkg::SCALER_VERSION_QUERY, 1'b0, 8'h00)};
    check(32'(host.got_q.size()), 32'd14);
    foreach (f[i]) check(host.got_q[i], f[i]);
    check(32'(n_cmd - cnt), 32'd2);
    check(32'(host.send_q.size()), 32'd0);
    check(rx_ready, 1'b1);
    // Reset in the middle of a header, then a clean frame
    f = '{8'h07, 8'hFF, 8'h53};
    foreach (f[i]) host.send_q.push_back(f[i]);
    repeat (10) @(negedge clk_sys_in);
    rstn_in = 1'b0;
    repeat (4) @(negedge clk_sys_in);
    check(cmd_code, 32'h0);
    check(rx_ready, 1'b0);
    check(tx_valid, 1'b0);
    rstn_in = 1'b1;
    repeat (2) @(negedge clk_sys_in);
    check(rx_ready, 1'b1);
    run('{8'h07, 8'hFF, 8'h53, 8'h57, 8'h49, 8'h00, 8'h06}, 1'b1, 0);
    wrap_up();
  end
endmodule : testbench

`default_nettype wire
